// *** hdl/wake_debounce_mode_sequencer.sv ***
// Wake timer, key debounce, stand-alone flow and automatic mode stepping
// How it works
// R1: Wake exponent is bits 7:4 of the wake divider, used within 1 to 10.
// R2: Wake multiplier is bits 3:0 of the wake divider, 0 to 15.
// R3: Wake interval is 2*(mult+1)*2^(exp+9) RC periods; stand-alone only; mult 0 disables.
// R4: Three-bit select picks debounce 470 us up to 480 ms; default 30 ms.
// R5: Stand-alone power-up loads configuration from the EEPROM, then sleeps.
// R6: A key press during sleep wakes the device and starts the RC oscillator.
// R7: After the debounce wait, fetch that key's frame and transmit it.
// R8: After transmission, put device and EEPROM back to sleep.
// R9: Clock output gives the clock divided from 1/2 down to 1/32 by select.
// R10: In host mode an SPI master host controls everything over five pins; the module has a parallel register port and command inputs instead.
// R11: From sleep to transmit, step modes: wait crystal ready, then synth lock.
// R12: Lock indication only in host mode, and only while no data is applied.
// R13: FSK settle is 5 us plus 1.25 us per ramp step plus half a bit.
// R14: OOK settle is 5 us plus half a bit, ramp ignored.
// R15: After lock, hold off transmit data until the settle time has passed.
// R16: One host command starts the whole sleep-to-transmit sequence.
// R17: The controlling party resets the device by driving reset high.
// R18: After reset the controlling party waits 5 ms before any operation.
// R19: Debounce and periodic wake are both timed in RC oscillator ticks.
`default_nettype none

module wake_debounce_mode_sequencer
    import wake_seq_pkg::*;
#(
    parameter int unsigned RESET_WAIT = RESET_WAIT_CYCLES,
    parameter int unsigned RC_DIV = RC_TICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic standalone_i,
    input wire logic key_press_i,
    input wire logic [3:0] key_id_i,
    input wire logic ee_done_i,
    input wire logic xtal_ready_i,
    input wire logic pll_lock_i,
    input wire logic tx_cmd_i,
    input wire logic sleep_cmd_i,
    input wire logic tx_done_i,
    input wire logic data_active_i,
    input wire logic ook_mode_i,
    input wire logic [3:0] pa_ramp_i,
    input wire logic [15:0] half_bit_cycles_i,
    input wire logic [2:0] clkout_sel_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic [1:0] mode_o,
    output logic rc_run_o,
    output logic ee_cfg_req_o,
    output logic ee_frame_req_o,
    output logic [3:0] frame_key_o,
    output logic ee_sleep_o,
    output logic tx_data_en_o,
    output logic lock_ind_o,
    output logic clk_out_o,
    output logic ready_o
);
    seq_state_t state_q, state_d;
    logic [7:0] wake_div_q, wake_div_d;
    logic [2:0] key_sel_q, key_sel_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [3:0] key_q, key_d;
    logic [4:0] div_cnt_q, div_cnt_d;
    logic ready_q, ready_d;
    logic rc_run_q, rc_run_d;
    logic clk_out_q, clk_out_d;
    logic lock_q, lock_d;
    radio_mode_t mode_q, mode_d;
    logic rc_tick, seq_load, seq_tick, seq_busy, seq_done, wake_load, wake_en, wake_done;
    logic [TMR_W-1:0] seq_val, settle_val, wake_val;
    logic [3:0] exp_eff;

    // =========================================================
    // Register port
    always_comb begin
        wake_div_d = wake_div_q;
        key_sel_d = key_sel_q;
        rdata_d = rdata_q;
        if (reg_wr_i && reg_addr_i == ADDR_WAKE_DIV) begin
            wake_div_d = reg_wdata_i; // R1 R2
        end
        if (reg_wr_i && reg_addr_i == ADDR_KEY_SETTLE) begin
            key_sel_d = reg_wdata_i[2:0]; // R4
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_WAKE_DIV: rdata_d = wake_div_q;
                ADDR_KEY_SETTLE: rdata_d = {KEY_SETTLE_PAD, key_sel_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wake_div_q <= WAKE_DIV_RESET;
            key_sel_q <= KEY_SETTLE_RESET;
            rdata_q <= '0;
        end else begin
            wake_div_q <= wake_div_d;
            key_sel_q <= key_sel_d;
            rdata_q <= rdata_d;
        end
    end

    // =========================================================
    // Interval arithmetic
    // Out-of-range exponents are pinned to the legal span rather than refused
    always_comb begin
        int unsigned settle_ns;
        int unsigned settle_cyc;
        settle_ns = SETTLE_BASE_NS;
        settle_cyc = 0;
        exp_eff = wake_div_q[EXP_MSB:EXP_LSB];
        if (exp_eff < EXP_MIN) begin
            exp_eff = EXP_MIN; // R1
        end else if (exp_eff > EXP_MAX) begin
            exp_eff = EXP_MAX; // R1
        end
        wake_val = (TMR_W'(wake_div_q[MUL_MSB:MUL_LSB]) + TMR_W'(1))
                   << (int'(exp_eff) + EXP_BIAS + 1); // R3
        if (!ook_mode_i) begin
            settle_ns = SETTLE_BASE_NS + RAMP_STEP_NS * int'(pa_ramp_i); // R13
        end
        // Least times round up to whole cycles
        settle_cyc = (settle_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                     + int'(half_bit_cycles_i); // R13 R14
        settle_val = TMR_W'(settle_cyc);
    end

    logic wake_busy_w;

    assign wake_en = standalone_i && state_q == S_SLEEP
                     && wake_div_q[MUL_MSB:MUL_LSB] != MUL_OFF; // R3
    assign wake_load = wake_en && !wake_busy_w;

    rc_tick_gen #(.DIV(RC_DIV)) u_rc (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(rc_run_q),
        .tick_o(rc_tick)
    );

    cycle_timer #(.W(TMR_W)) u_wake (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(wake_load),
        .val_i(wake_val),
        .tick_i(rc_tick), // R19
        .stop_i(!wake_en),
        .busy_o(wake_busy_w),
        .done_o(wake_done)
    );

    cycle_timer #(.W(TMR_W)) u_seq (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(seq_load),
        .val_i(seq_val),
        .tick_i(seq_tick),
        .stop_i(1'b0),
        .busy_o(seq_busy),
        .done_o(seq_done)
    );

    assign seq_tick = (state_q == S_DEBOUNCE) ? rc_tick : 1'b1; // R19

    // =========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        key_d = key_q;
        ready_d = ready_q;
        seq_load = 1'b0;
        seq_val = settle_val;
        case (state_q)
            S_BOOT: begin
                seq_load = 1'b1;
                seq_val = TMR_W'(RESET_WAIT); // R18
                state_d = S_RST_WAIT;
            end
            S_RST_WAIT: begin
                if (seq_done) begin
                    ready_d = 1'b1;
                    state_d = standalone_i ? S_LOAD_CFG : S_SLEEP; // R5
                end
            end
            S_LOAD_CFG: begin
                if (ee_done_i) begin
                    state_d = S_SLEEP; // R5
                end
            end
            S_SLEEP: begin
                if (standalone_i && key_press_i) begin
                    key_d = key_id_i;
                    seq_load = 1'b1;
                    seq_val = key_settle_ticks(key_sel_q); // R4
                    state_d = S_DEBOUNCE; // R6
                end else if (wake_done) begin
                    key_d = '0;
                    state_d = S_FETCH; // R3
                end else if (!standalone_i && tx_cmd_i) begin
                    state_d = S_XTAL; // R16
                end
            end
            S_DEBOUNCE: begin
                if (seq_done) begin
                    state_d = S_FETCH; // R7
                end
            end
            S_FETCH: begin
                if (ee_done_i) begin
                    state_d = S_XTAL; // R7
                end
            end
            S_XTAL: begin
                if (xtal_ready_i) begin
                    state_d = S_PLL; // R11
                end
            end
            S_PLL: begin
                if (pll_lock_i) begin
                    seq_load = 1'b1; // R15
                    state_d = S_SETTLE; // R11
                end
            end
            S_SETTLE: begin
                if (seq_done) begin
                    state_d = S_TX; // R15
                end
            end
            S_TX: begin
                if (standalone_i && tx_done_i) begin
                    state_d = S_EE_SLEEP; // R8
                end
            end
            S_EE_SLEEP: begin
                state_d = S_SLEEP; // R8
            end
            default: begin
                state_d = S_BOOT;
            end
        endcase
        // The host may abort a sequence in crystal wait, synth lock, settle or transmit back to sleep
        if (!standalone_i && sleep_cmd_i
            && (state_q == S_XTAL || state_q == S_PLL
                || state_q == S_SETTLE || state_q == S_TX)) begin
            state_d = S_SLEEP;
        end
    end

    // =========================================================
    // Outputs; mode, RC run, lock and clock come from flops; the EEPROM, sleep and data enables decode the state directly
    always_comb begin
        case (state_d)
            S_XTAL: mode_d = MODE_STANDBY;
            S_PLL: mode_d = MODE_SYNTH;
            S_SETTLE, S_TX: mode_d = MODE_TX;
            default: mode_d = MODE_SLEEP;
        endcase
        rc_run_d = state_d == S_DEBOUNCE
                   || (state_d == S_SLEEP && wake_en); // R6 R19
        lock_d = !standalone_i && pll_lock_i && !data_active_i
                 && (state_d == S_PLL || state_d == S_SETTLE || state_d == S_TX); // R12
        div_cnt_d = div_cnt_q + 5'h01;
        clk_out_d = div_cnt_d[clkout_sel_i > 3'h4 ? 3'h4 : clkout_sel_i]; // R9
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= S_BOOT;
            key_q <= '0;
            ready_q <= 1'b0;
            mode_q <= MODE_SLEEP;
            rc_run_q <= 1'b0;
            lock_q <= 1'b0;
            div_cnt_q <= '0;
            clk_out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            key_q <= key_d;
            ready_q <= ready_d;
            mode_q <= mode_d;
            rc_run_q <= rc_run_d;
            lock_q <= lock_d;
            div_cnt_q <= div_cnt_d;
            clk_out_q <= clk_out_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign mode_o = mode_q;
    assign rc_run_o = rc_run_q;
    assign ee_cfg_req_o = state_q == S_LOAD_CFG;
    assign ee_frame_req_o = state_q == S_FETCH;
    assign frame_key_o = key_q;
    assign ee_sleep_o = state_q == S_EE_SLEEP;
    assign tx_data_en_o = state_q == S_TX; // R15
    assign lock_ind_o = lock_q;
    assign clk_out_o = clk_out_q;
    assign ready_o = ready_q;

    // =========================================================
    // Checks
    logic [TMR_W-1:0] settle_cyc_q, settle_need_q;
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            settle_cyc_q <= '0;
            settle_need_q <= '0;
        end else if (state_q == S_PLL && state_d == S_SETTLE) begin
            settle_cyc_q <= '0;
            settle_need_q <= settle_val;
        end else if (state_q == S_SETTLE) begin
            settle_cyc_q <= settle_cyc_q + 1'b1;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // An in-span field must be used as stored, not only kept inside the span
    property p_exp_span;
        exp_eff >= EXP_MIN && exp_eff <= EXP_MAX
        && (wake_div_q[EXP_MSB:EXP_LSB] < EXP_MIN || wake_div_q[EXP_MSB:EXP_LSB] > EXP_MAX
            || exp_eff == wake_div_q[EXP_MSB:EXP_LSB]);
    endproperty
    a_exp_span: assert property (p_exp_span) else $error("wake exponent out of span"); // R1
    property p_mul_write;
        reg_wr_i && reg_addr_i == ADDR_WAKE_DIV |=> wake_div_q[3:0] == $past(reg_wdata_i[3:0]);
    endproperty
    a_mul_write: assert property (p_mul_write) else $error("multiplier not stored"); // R2
    property p_wake_off;
        wake_div_q[MUL_MSB:MUL_LSB] == MUL_OFF || !standalone_i |=> !wake_busy_w && !wake_done;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("wake timer ran while off"); // R3
    property p_cfg_then_sleep;
        state_q == S_LOAD_CFG && ee_done_i |=> state_q == S_SLEEP && mode_o == MODE_SLEEP;
    endproperty
    a_cfg_then_sleep: assert property (p_cfg_then_sleep) else $error("no sleep after config"); // R5
    property p_key_wake;
        state_q == S_SLEEP && standalone_i && key_press_i |=> state_q == S_DEBOUNCE && rc_run_o;
    endproperty
    a_key_wake: assert property (p_key_wake) else $error("key press did not wake"); // R6
    property p_fetch_after_deb;
        state_q == S_DEBOUNCE && seq_done |=> ee_frame_req_o ##0 frame_key_o == $past(key_q);
    endproperty
    a_fetch_after_deb: assert property (p_fetch_after_deb) else $error("no fetch after debounce"); // R7
    property p_back_to_sleep;
        state_q == S_TX && standalone_i && tx_done_i |=> ee_sleep_o ##1 mode_o == MODE_SLEEP;
    endproperty
    a_back_to_sleep: assert property (p_back_to_sleep) else $error("no return to sleep"); // R8
    property p_step_order;
        state_q == S_XTAL && !xtal_ready_i |=> mode_o != MODE_TX;
    endproperty
    a_step_order: assert property (p_step_order) else $error("transmit before crystal"); // R11
    property p_lock_valid;
        lock_ind_o |-> !$past(data_active_i) && !$past(standalone_i);
    endproperty
    a_lock_valid: assert property (p_lock_valid) else $error("lock shown while invalid"); // R12
    property p_settle_time;
        $past(state_q) == S_SETTLE && state_q == S_TX |-> settle_cyc_q > settle_need_q;
    endproperty
    a_settle_time: assert property (p_settle_time) else $error("data before settle"); // R13 R14 R15
    property p_one_cmd;
        state_q == S_SLEEP && !standalone_i && tx_cmd_i |=> mode_o == MODE_STANDBY;
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("command did not start"); // R16
    property p_clk_full;
        !$past(sys_rst_i) && clkout_sel_i == 3'h0 && $past(clkout_sel_i) == 3'h0
        && $past(clkout_sel_i, 2) == 3'h0 |-> clk_out_o != $past(clk_out_o);
    endproperty
    a_clk_full: assert property (p_clk_full) else $error("clock output not toggling"); // R9

    c_key_tx: cover property (state_q == S_DEBOUNCE ##[1:1000] state_q == S_TX);
    c_host_tx: cover property (!standalone_i && tx_cmd_i ##[1:1000] tx_data_en_o);
    c_periodic: cover property (state_q == S_SLEEP && wake_done);
endmodule

`default_nettype wire

// *** hdl/wake_seq_pkg.sv ***
// Shared constants, types and timing figures for the wake and mode sequencer
`default_nettype none

package wake_seq_pkg;

    // =========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    // RC oscillator period in ns; the value is a plain default
    localparam int unsigned RC_PERIOD_NS = 10000;
    localparam int unsigned RC_TICK_CYCLES = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_WAIT_NS = 5000000;
    localparam int unsigned RESET_WAIT_CYCLES = RESET_WAIT_NS / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_BASE_NS = 5000;
    localparam int unsigned RAMP_STEP_NS = 1250;
    localparam int unsigned TMR_W = 26;

    // =========================================================
    // Register map
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam logic [6:0] ADDR_WAKE_DIV = 7'h17;
    localparam logic [6:0] ADDR_KEY_SETTLE = 7'h18;
    localparam logic [7:0] WAKE_DIV_RESET = 8'h00;
    localparam logic [2:0] KEY_SETTLE_RESET = 3'h3;
    localparam int unsigned EXP_MSB = 7;
    localparam int unsigned EXP_LSB = 4;
    localparam int unsigned MUL_MSB = 3;
    localparam int unsigned MUL_LSB = 0;
    localparam logic [3:0] EXP_MIN = 4'h1;
    localparam logic [3:0] EXP_MAX = 4'ha;
    localparam logic [3:0] MUL_OFF = 4'h0;
    localparam int unsigned EXP_BIAS = 9;
    localparam logic [4:0] KEY_SETTLE_PAD = 5'h00;

    // Debounce times in microseconds, indexed by the select field
    localparam int unsigned KEY_SETTLE_US [8] = '{470, 7500, 15000, 30000,
                                                  60000, 120000, 240000, 480000};

    function automatic logic [TMR_W-1:0] key_settle_ticks(input logic [2:0] sel);
        int unsigned ns;
        ns = KEY_SETTLE_US[sel] * 1000;
        return TMR_W'((ns + RC_PERIOD_NS - 1) / RC_PERIOD_NS);
    endfunction

    // =========================================================
    // Modes and states
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'h0,
        MODE_STANDBY = 2'h1,
        MODE_SYNTH = 2'h2,
        MODE_TX = 2'h3
    } radio_mode_t;

    typedef enum logic [10:0] {
        S_BOOT = 11'h001,
        S_RST_WAIT = 11'h002,
        S_LOAD_CFG = 11'h004,
        S_SLEEP = 11'h008,
        S_DEBOUNCE = 11'h010,
        S_FETCH = 11'h020,
        S_XTAL = 11'h040,
        S_PLL = 11'h080,
        S_SETTLE = 11'h100,
        S_TX = 11'h200,
        S_EE_SLEEP = 11'h400
    } seq_state_t;

endpackage

`default_nettype wire

// *** hdl/rc_tick_gen.sv ***
// Divider that stands in for the RC oscillator as a one-cycle tick
`default_nettype none

module rc_tick_gen #(
    parameter int unsigned DIV = 100
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic en_i,
    output logic tick_o
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    // =========================================================
    // Counter
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!en_i) begin
            cnt_d = '0;
        end else if (cnt_q == LAST) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule

`default_nettype wire

// *** hdl/cycle_timer.sv ***
// Loadable down-counter that pulses once after a given number of ticks
`default_nettype none

module cycle_timer #(
    parameter int unsigned W = 26
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] val_i,
    input wire logic tick_i,
    input wire logic stop_i,
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    // =========================================================
    // Count
    // A load of zero finishes on the first tick, like a load of one
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (load_i) begin
            cnt_d = val_i;
            busy_d = 1'b1;
        end else if (stop_i) begin
            busy_d = 1'b0;
        end else if (busy_q && tick_i) begin
            if (cnt_q <= W'(1)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
endmodule

`default_nettype wire

// *** testbench/far_side_model.sv ***
// Far-side model: EEPROM reads, crystal, synthesizer and frame sender
`default_nettype none
module far_side_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic cfg_req_i,
    input wire logic frame_req_i,
    input wire logic [1:0] mode_i,
    input wire logic data_en_i,
    output logic done_o,
    output logic xtal_o,
    output logic lock_o,
    output logic sent_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned req_cnt;
    int unsigned en_cnt;
    // ==========
    // Answers
    // Reads take four cycles, so a request dropped early is never answered
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_cnt <= 0;
            en_cnt <= 0;
            done_o <= 1'b0;
            xtal_o <= 1'b0;
            lock_o <= 1'b0;
            sent_o <= 1'b0;
        end else begin
            req_cnt <= (cfg_req_i || frame_req_i) ? req_cnt + 1 : 0;
            done_o <= (cfg_req_i || frame_req_i) && req_cnt == 3;
            xtal_o <= mode_i != 2'h0;
            lock_o <= xtal_o && mode_i[1];
            en_cnt <= data_en_i ? en_cnt + 1 : 0;
            sent_o <= data_en_i && en_cnt == 7;
        end
    end
endmodule
`default_nettype wire

// *** testbench/wake_debounce_mode_sequencer_test.sv ***
// Self-checking bench for the wake, debounce and mode sequencer
`default_nettype none
module wake_debounce_mode_sequencer_test
    import wake_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned RW = 20;
    logic core_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = 7'h00;
    logic [DATA_W-1:0] reg_wdata_i = 8'h00;
    logic standalone_i = 1'b1, key_press_i = 1'b0, tx_cmd_i = 1'b0, sleep_cmd_i = 1'b0;
    logic data_active_i = 1'b0, ook_mode_i = 1'b1;
    logic [3:0] key_id_i = 4'h0, pa_ramp_i = 4'h0, frame_key_o;
    logic [15:0] half_bit_cycles_i = 16'h0002;
    logic [2:0] clkout_sel_i = 3'h0;
    logic ee_done_i, xtal_ready_i, pll_lock_i, tx_done_i, rc_run_o, ee_cfg_req_o;
    logic ee_frame_req_o, ee_sleep_o, tx_data_en_o, lock_ind_o, clk_out_o, ready_o;
    logic [DATA_W-1:0] reg_rdata_o;
    logic [1:0] mode_o;
    int failures = 0, comparisons = 0;
    wake_debounce_mode_sequencer #(.RESET_WAIT(RW), .RC_DIV(1)) DUT (
        .core_clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
        .standalone_i, .key_press_i, .key_id_i, .ee_done_i, .xtal_ready_i,
        .pll_lock_i, .tx_cmd_i, .sleep_cmd_i, .tx_done_i, .data_active_i,
        .ook_mode_i, .pa_ramp_i, .half_bit_cycles_i, .clkout_sel_i, .reg_rdata_o,
        .mode_o, .rc_run_o, .ee_cfg_req_o, .ee_frame_req_o, .frame_key_o,
        .ee_sleep_o, .tx_data_en_o, .lock_ind_o, .clk_out_o, .ready_o);
    far_side_model far (.core_clk_i, .sys_rst_i, .cfg_req_i(ee_cfg_req_o),
        .frame_req_i(ee_frame_req_o), .mode_i(mode_o), .data_en_i(tx_data_en_o),
        .done_o(ee_done_i), .xtal_o(xtal_ready_i), .lock_o(pll_lock_i), .sent_o(tx_done_i));
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    // ==========
    // Shared tasks
    task automatic complete_run;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Polls at falling edges so registered outputs have settled
    task automatic wait_hi(input int s, input int lim, output int n);
        logic v;
        n = 0;
        v = 1'b0;
        while (v !== 1'b1) begin
            @(negedge core_clk_i);
            n++;
            case (s)
                0: v = ready_o;
                1: v = ee_cfg_req_o;
                2: v = ee_frame_req_o;
                3: v = tx_data_en_o;
                4: v = ee_sleep_o;
                5: v = (mode_o == 2'h3);
                6: v = !ee_cfg_req_o;
                default: v = rc_run_o;
            endcase
            if (n > lim) begin
                failures++;
                $display("Error at %0t: wait %0d ran out", $time, s);
                complete_run();
            end
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk({8'h00, reg_rdata_o}, {8'h00, e});
    endtask
    task automatic pulse_cmd(input logic key);
        @(posedge core_clk_i);
        if (key) key_press_i <= 1'b1;
        else tx_cmd_i <= 1'b1;
        @(posedge core_clk_i);
        key_press_i <= 1'b0;
        tx_cmd_i <= 1'b0;
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        int n;
        wait_hi(0, RW + 4, n);
        chk(16'(n >= RW), 16'h1);
        wait_hi(1, 4, n);
        wait_hi(6, 10, n);
        chk({14'h0, mode_o}, 16'h0);
        rd(7'h17, 8'h00);
        rd(7'h18, 8'h03);
    endtask
    task automatic t_regs;
        wr(7'h17, 8'ha5);
        rd(7'h17, 8'ha5);
        wr(7'h18, 8'hff);
        rd(7'h18, 8'h07);
        wr(7'h18, 8'h00);
        rd(7'h18, 8'h00);
        wr(7'h16, 8'h5a);
        rd(7'h16, 8'h00);
    endtask
    task automatic t_key;
        int n;
        wr(7'h17, 8'h11);
        key_id_i <= 4'h5;
        pulse_cmd(1'b1);
        wait_hi(7, 3, n);
        wait_hi(2, 60, n);
        chk(16'(n >= 47), 16'h1);
        chk({12'h0, frame_key_o}, 16'h5);
        wait_hi(3, 200, n);
        chk({15'h0, lock_ind_o}, 16'h0);
        wait_hi(4, 30, n);
        chk({14'h0, mode_o}, 16'h0);
    endtask
    task automatic t_wake;
        int n;
        wait_hi(2, 4110, n);
        chk(16'(n >= 4090), 16'h1);
        chk({12'h0, frame_key_o}, 16'h0);
        wait_hi(4, 300, n);
        wr(7'h17, 8'h10);
        n = 0;
        repeat (5000) begin
            @(negedge core_clk_i);
            if (ee_frame_req_o !== 1'b0) n++;
        end
        chk(16'(n), 16'h0);
    endtask
    task automatic t_host(input logic ook, input int unsigned expn);
        int n;
        @(posedge core_clk_i);
        standalone_i <= 1'b0;
        ook_mode_i <= ook;
        pa_ramp_i <= 4'h4;
        half_bit_cycles_i <= 16'h000a;
        pulse_cmd(1'b0);
        wait_hi(5, 30, n);
        wait_hi(3, 200, n);
        chk(16'(n >= expn && n <= expn + 2), 16'h1);
        chk({15'h0, lock_ind_o}, 16'h1);
        @(posedge core_clk_i);
        data_active_i <= 1'b1;
        repeat (3) @(negedge core_clk_i);
        chk({15'h0, lock_ind_o}, 16'h0);
        @(posedge core_clk_i);
        data_active_i <= 1'b0;
        sleep_cmd_i <= 1'b1;
        @(posedge core_clk_i);
        sleep_cmd_i <= 1'b0;
        repeat (3) @(negedge core_clk_i);
        chk({14'h0, mode_o}, 16'h0);
    endtask
    task automatic t_clk;
        int n;
        logic last;
        for (int s = 0; s < 6; s++) begin
            @(posedge core_clk_i);
            clkout_sel_i <= 3'(s);
            repeat (3) @(negedge core_clk_i);
            n = 0;
            last = clk_out_o;
            repeat (64) begin
                @(negedge core_clk_i);
                if (clk_out_o !== last) n++;
                last = clk_out_o;
            end
            chk(16'(n), 16'(64 >> (s > 4 ? 4 : s)));
        end
    endtask
    initial begin
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_key();
        t_wake();
        t_host(1'b0, 110);
        t_host(1'b1, 60);
        t_clk();
        complete_run();
    end
endmodule
`default_nettype wire
